// ### common/tmc_defines.vh
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// register word indices; byte address is index * 4
`define TMC_IX_CFG   6'h00
`define TMC_IX_PTR   6'h01
`define TMC_IX_DATA  6'h02
`define TMC_IX_STS1  6'h03
`define TMC_IX_STS2  6'h04
`define TMC_IX_MSK1  6'h05
`define TMC_IX_MSK2  6'h06
`define TMC_IX_ADDR  6'h07
`define TMC_IX_VAL   6'h08
`define TMC_IX_LOW   6'h0d
`define TMC_IX_HIGH  6'h12
`define TMC_IX_FLIM  6'h17
`define TMC_IX_FVAL  6'h1b
`define TMC_IX_OFS   6'h1f
`define TMC_IX_FAN_START_TEMPERATURE  6'h22
`define TMC_IX_TRNG  6'h25
`define TMC_IX_OPNT  6'h28
`define TMC_IX_ACOU  6'h2b
`define TMC_IX_DRV   6'h2e
`define TMC_IX_LAST  6'h30
`define TMC_NREG     49

// configuration bits
`define TMC_CFG_START   0
`define TMC_CFG_ALERT5  1
`define TMC_CFG_ALERT14 2
`define TMC_CFG_DYN     3

// field positions and sizes
`define TMC_ADDR_LOCK   7
`define TMC_TRNG_MSB    2
`define TMC_NZONE       3

// channels: 0 2.5 V, 1 supply, 2 remote one, 3 local, 4 remote two
`define TMC_CH_FIRST 3'h0
`define TMC_CH_T0    3'h2
`define TMC_CH_LAST  3'h4

// reset values and saturation
`define TMC_RST_LOW   8'h00
`define TMC_RST_HIGH  8'hff
`define TMC_TEMP_MAX  8'h7f
`define TMC_TEMP_MIN  8'h80
`define TMC_DRV_MAX   8'hff
`define TMC_ZERO8     8'h00
`define TMC_ONE8      8'h01

// slave addresses
`define TMC_ADDR_DEFAULT 7'h2e
`define TMC_ADDR_SEL0    7'h2c
`define TMC_ADDR_SEL1    7'h2d

// edges after reset release before the strap is trusted
`define TMC_STRAP_SETTLE 2'h3

`endif

// ### hw/tmc_core.v
// Behaviour
// - strap low: address pin picks slave address
// - strap high: slave address 0x2e
// - select low 0x2c, high 0x2d; sampled once
// - address locks on first match; straps ignored
// - all configuration only through the bus
// - started monitor cycles channels in fixed order
// - five channels, each with value register
// - conversion result stored, readable by host
// - value compared with limits, status bit recorded
// - status covers temperature, voltage and fans
// - alert assignable to either of two pins
// - alert pin low on unmasked status
// - one mask bit per status event
// - first write byte loads address pointer
// - data via pointer; reads need no rewrite
// - signed offset added to temperature readings
// - start temperature begins fan ramp
// - range register sets drive slope
// - operating point steers start temperature
// - acoustic register limits drive step size
// - configuration register selects pin functions
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_defines.vh"
module tmc_core (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // converter
    output wire        adc_start,
    output wire [2:0]  adc_chan,
    input  wire        adc_done,
    input  wire [7:0]  adc_data,
    // fan speed results
    input  wire        fan_valid,
    input  wire [1:0]  fan_idx,
    input  wire [7:0]  fan_value,
    // address straps
    input  wire        addr_enable_pin,
    input  wire        addr_select_pin,
    input  wire        addr_latch,
    output reg  [6:0]  slave_addr,
    output reg         addr_locked,
    // alert pins, open drain
    output wire        alert5_o,
    output reg         alert5_oe_n,
    output wire        alert14_o,
    output reg         alert14_oe_n,
    // fan drive per zone
    output wire [23:0] fan_drive
);

    localparam S_IDLE = 2'b00;
    localparam S_REQ  = 2'b01;
    localparam S_WAIT = 2'b10;

    reg  [7:0] mem [0:`TMC_NREG-1];
    reg  [7:0] ptr_q;
    reg  [1:0] st_q;
    reg  [2:0] ch_q;
    reg  [2:0] en_s_q;
    reg  [2:0] sel_s_q;
    reg  [1:0] settle_q;
    reg        captured_q;
    integer    i;

    // ---------------- bus decode ----------------
    wire [5:0] idx;
    wire       mapped;
    wire       acc;
    wire [5:0] tgt;
    wire       tgt_ok;
    wire       ok;
    wire       wr;
    wire       tgt_rw;
    wire [7:0] clr1;
    wire [7:0] clr2;
    wire [7:0] cfg;

    assign idx    = paddr[7:2];
    assign mapped = idx <= `TMC_IX_LAST;
    assign acc    = psel & penable;
    // data window goes through the pointer
    assign tgt    = (idx == `TMC_IX_DATA) ? ptr_q[5:0] : idx;
    assign tgt_ok = (idx != `TMC_IX_DATA) |
                    (ptr_q <= {2'b00, `TMC_IX_LAST});
    assign ok     = mapped & tgt_ok;
    assign wr     = acc & pwrite & ok;
    assign pready = 1'b1;
    assign pslverr = acc & ~ok;

    // value, address and drive registers are read only
    assign tgt_rw = (tgt == `TMC_IX_CFG) |
                    (tgt == `TMC_IX_MSK1) |
                    (tgt == `TMC_IX_MSK2) |
                    ((tgt >= `TMC_IX_LOW) &&
                     (tgt < `TMC_IX_FVAL)) |
                    ((tgt >= `TMC_IX_OFS) &&
                     (tgt < `TMC_IX_DRV));

    assign clr1 = (wr && tgt == `TMC_IX_STS1) ?
                  pwdata[7:0] : `TMC_ZERO8;
    assign clr2 = (wr && tgt == `TMC_IX_STS2) ?
                  pwdata[7:0] : `TMC_ZERO8;
    assign cfg  = mem[`TMC_IX_CFG];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= `TMC_ZERO8;
        end else if (wr && idx == `TMC_IX_PTR) begin
            ptr_q <= pwdata[7:0];
        end
    end

    // read data captured in setup so it is a flop in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (!ok) begin
                prdata <= 32'h0000_0000;
            end else if (tgt == `TMC_IX_PTR) begin
                prdata <= {24'h00_0000, ptr_q};
            end else begin
                prdata <= {24'h00_0000, mem[tgt]};
            end
        end
    end

    // ---------------- measurement sequencer ----------------
    wire       conv;
    wire       is_temp;
    wire [2:0] zone;
    wire [7:0] ofs;
    wire [8:0] sum9;
    wire [7:0] adj;
    wire [7:0] lo;
    wire [7:0] hi;
    wire       out_lim;
    wire [7:0] flim;
    wire       fan_bad;
    wire [7:0] set1;
    wire [7:0] set2;

    assign adc_start = (st_q == S_REQ);
    assign adc_chan  = ch_q;
    assign conv      = (st_q == S_WAIT) & adc_done;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            ch_q <= `TMC_CH_FIRST;
        end else begin
            case (st_q)
            S_IDLE: begin
                if (cfg[`TMC_CFG_START]) begin
                    st_q <= S_REQ;
                end
            end
            S_REQ: begin
                st_q <= S_WAIT;
            end
            S_WAIT: begin
                if (adc_done) begin
                    // fixed round robin over all five inputs
                    if (ch_q == `TMC_CH_LAST) begin
                        ch_q <= `TMC_CH_FIRST;
                    end else begin
                        ch_q <= ch_q + 3'h1;
                    end
                    if (cfg[`TMC_CFG_START]) begin
                        st_q <= S_REQ;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
            end
            default: begin
                st_q <= S_IDLE;
            end
            endcase
        end
    end

    // offset added with saturation so a hot reading never wraps cold
    assign is_temp = ch_q >= `TMC_CH_T0;
    assign zone    = ch_q - `TMC_CH_T0;
    assign ofs     = mem[`TMC_IX_OFS + {3'h0, zone}];
    assign sum9    = {adc_data[7], adc_data} + {ofs[7], ofs};
    assign adj     = !is_temp ? adc_data :
                     (sum9[8] == sum9[7]) ? sum9[7:0] :
                     sum9[8] ? `TMC_TEMP_MIN : `TMC_TEMP_MAX;

    assign lo = mem[`TMC_IX_LOW + {3'h0, ch_q}];
    assign hi = mem[`TMC_IX_HIGH + {3'h0, ch_q}];
    // temperatures are signed, voltages unsigned
    assign out_lim = is_temp ?
        (($signed(adj) > $signed(hi)) |
         ($signed(adj) < $signed(lo))) :
        ((adj > hi) | (adj < lo));

    // a fan reading below its limit means a slow or stalled fan
    assign flim    = mem[`TMC_IX_FLIM + {4'h0, fan_idx}];
    assign fan_bad = fan_value < flim;

    assign set1 = (conv && out_lim) ?
                  (`TMC_ONE8 << ch_q) : `TMC_ZERO8;
    assign set2 = (fan_valid && fan_bad) ?
                  (`TMC_ONE8 << fan_idx) : `TMC_ZERO8;

    // ---------------- register file ----------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `TMC_NREG; i = i + 1) begin
                if (i >= `TMC_IX_HIGH && i < `TMC_IX_FLIM) begin
                    mem[i] <= `TMC_RST_HIGH;
                end else begin
                    mem[i] <= `TMC_RST_LOW;
                end
            end
        end else begin
            if (wr && tgt_rw) begin
                mem[tgt] <= pwdata[7:0];
            end
            if (conv) begin
                mem[`TMC_IX_VAL + {3'h0, ch_q}] <= adj;
            end
            if (fan_valid) begin
                mem[`TMC_IX_FVAL + {4'h0, fan_idx}] <= fan_value;
            end
            // a new event beats a clear in the same cycle
            mem[`TMC_IX_STS1] <= (mem[`TMC_IX_STS1] & ~clr1) |
                                 set1;
            mem[`TMC_IX_STS2] <= (mem[`TMC_IX_STS2] & ~clr2) |
                                 set2;
            mem[`TMC_IX_ADDR] <= {addr_locked, slave_addr};
            for (i = 0; i < `TMC_NZONE; i = i + 1) begin
                mem[`TMC_IX_DRV + i] <= fan_drive[8*i +: 8];
            end
        end
    end

    // ---------------- alert ----------------
    wire pending;

    assign pending =
        (|(mem[`TMC_IX_STS1] & ~mem[`TMC_IX_MSK1])) |
        (|(mem[`TMC_IX_STS2] & ~mem[`TMC_IX_MSK2]));
    assign alert5_o  = 1'b0;
    assign alert14_o = 1'b0;

    // registered so the open drain never glitches on decode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert5_oe_n  <= 1'b1;
            alert14_oe_n <= 1'b1;
        end else begin
            alert5_oe_n  <= ~(cfg[`TMC_CFG_ALERT5] & pending);
            alert14_oe_n <= ~(cfg[`TMC_CFG_ALERT14] & pending);
        end
    end

    // ---------------- address strap ----------------
    wire [6:0] strap_addr;
    wire       strap_stable;

    // stage 0 is only read by stage 1
    assign strap_stable = (en_s_q[1] == en_s_q[2]) &
                          (sel_s_q[1] == sel_s_q[2]);
    assign strap_addr = en_s_q[2] ? `TMC_ADDR_DEFAULT :
                        sel_s_q[2] ? `TMC_ADDR_SEL1 :
                        `TMC_ADDR_SEL0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_s_q  <= 3'h7;
            sel_s_q <= 3'h0;
        end else begin
            en_s_q  <= {en_s_q[1:0], addr_enable_pin};
            sel_s_q <= {sel_s_q[1:0], addr_select_pin};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q    <= 2'h0;
            captured_q  <= 1'b0;
            slave_addr  <= `TMC_ADDR_DEFAULT;
            addr_locked <= 1'b0;
        end else begin
            if (settle_q != `TMC_STRAP_SETTLE) begin
                settle_q <= settle_q + 2'h1;
            end
            // one capture after release; later strap moves ignored
            if (!captured_q && strap_stable &&
                settle_q == `TMC_STRAP_SETTLE) begin
                captured_q <= 1'b1;
                slave_addr <= strap_addr;
            end
            if (addr_latch && captured_q) begin
                addr_locked <= 1'b1;
            end
        end
    end

    // ---------------- automatic fan control ----------------
    genvar z;
    generate
        for (z = 0; z < `TMC_NZONE; z = z + 1) begin : g_zone
            localparam [2:0] ZCH = `TMC_CH_T0 + z;
            reg  [7:0]  fan_start_temperature_eff_q;
            reg  [7:0]  drv_q;
            wire        hit;
            wire [7:0]  fan_start_temperature;
            wire [7:0]  trng;
            wire [7:0]  opnt;
            wire [7:0]  acou;
            wire [7:0]  fan_start_temperature_use;
            wire [7:0]  diff;
            wire [15:0] scaled;
            wire        above;
            wire [7:0]  want;
            wire [7:0]  up;
            wire [7:0]  dn;

            assign hit  = conv && (ch_q == ZCH);
            assign fan_start_temperature = mem[`TMC_IX_FAN_START_TEMPERATURE + z];
            assign trng = mem[`TMC_IX_TRNG + z];
            assign opnt = mem[`TMC_IX_OPNT + z];
            assign acou = mem[`TMC_IX_ACOU + z];
            // programmed start applies at once outside dynamic mode
            assign fan_start_temperature_use = cfg[`TMC_CFG_DYN] ? fan_start_temperature_eff_q : fan_start_temperature;
            assign above = $signed(adj) > $signed(fan_start_temperature_use);
            assign diff  = adj - fan_start_temperature_use;
            assign scaled = {`TMC_ZERO8, diff} <<
                            trng[`TMC_TRNG_MSB:0];
            assign want = !above ? `TMC_ZERO8 :
                          (|scaled[15:8]) ? `TMC_DRV_MAX :
                          scaled[7:0];
            assign up = want - drv_q;
            assign dn = drv_q - want;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fan_start_temperature_eff_q <= `TMC_ZERO8;
                    drv_q      <= `TMC_ZERO8;
                end else if (hit) begin
                    // dynamic mode walks the start point one step
                    if (!cfg[`TMC_CFG_DYN]) begin
                        fan_start_temperature_eff_q <= fan_start_temperature;
                    end else if ($signed(adj) > $signed(opnt) &&
                                 fan_start_temperature_eff_q != `TMC_ZERO8) begin
                        fan_start_temperature_eff_q <= fan_start_temperature_eff_q - `TMC_ONE8;
                    end else if ($signed(adj) < $signed(opnt) &&
                                 fan_start_temperature_eff_q < fan_start_temperature) begin
                        fan_start_temperature_eff_q <= fan_start_temperature_eff_q + `TMC_ONE8;
                    end
                    // zero step size means no smoothing
                    if (acou == `TMC_ZERO8) begin
                        drv_q <= want;
                    end else if (want > drv_q) begin
                        drv_q <= (up > acou) ?
                                 drv_q + acou : want;
                    end else begin
                        drv_q <= (dn > acou) ?
                                 drv_q - acou : want;
                    end
                end
            end

            assign fan_drive[8*z +: 8] = drv_q;
        end
    endgenerate

endmodule
`default_nettype wire

// ### test/tmc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_adc_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // conversion request and pacing
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_chan,
    input  wire logic [3:0]  delay,
    input  wire logic [39:0] chan_vals,
    // conversion answer
    output var  logic        adc_done,
    output var  logic [7:0]  adc_data
);
    logic [3:0] left_q;
    logic       busy_q;
    logic       fin;

    // a result is due once the count has run out
    assign fin = busy_q && left_q == 4'h0 && !adc_start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q   <= 1'b0;
            left_q   <= 4'h0;
            adc_done <= 1'b0;
            adc_data <= 8'h00;
        end else begin
            adc_done <= fin;
            // data is only meaningful with done, so it churns otherwise
            adc_data <= fin ? chan_vals[adc_chan*8 +: 8] : ~adc_data;
            if (adc_start) begin
                busy_q <= 1'b1;
                left_q <= delay;
            end else if (fin) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tmc_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_defines.vh"
module tmc_core_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // converter
    input wire logic        adc_start,
    input wire logic [2:0]  adc_chan,
    input wire logic        adc_done,
    // straps and results
    input wire logic        addr_enable_pin,
    input wire logic        addr_select_pin,
    input wire logic        addr_latch,
    input wire logic [6:0]  slave_addr,
    input wire logic        addr_locked,
    input wire logic [23:0] fan_drive
);
    logic [2:0] cnt_q;
    logic [2:0] last_q;
    logic       seen_q;
    logic [6:0] strap_addr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign strap_addr = addr_enable_pin ? `TMC_ADDR_DEFAULT :
        (addr_select_pin ? `TMC_ADDR_SEL1 : `TMC_ADDR_SEL0);

    // edges since reset release, saturating at 7
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 3'h0;
            seen_q <= 1'b0;
            last_q <= 3'h0;
        end else begin
            if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
            if (adc_start) seen_q <= 1'b1;
            if (adc_start) last_q <= adc_chan;
        end
    end

    property p_slverr;
        psel && penable && (paddr[7:2] > `TMC_IX_LAST) |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not refused");
    property p_rd_hold;
        psel && penable |=> $stable(prdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved after access");
    property p_start_pulse;
        adc_start |=> !adc_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("conversion start longer than one cycle");
    property p_chan_seq;
        adc_start && seen_q |->
            adc_chan == ((last_q == `TMC_CH_LAST) ? 3'h0 : last_q + 3'h1);
    endproperty
    a_chan_seq: assert property (p_chan_seq)
        else $error("channel order broken");
    property p_chan_hold;
        !adc_done |=> $stable(adc_chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel moved without a result");
    property p_drive_cause;
        $changed(fan_drive) |-> $past(adc_done);
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("fan drive moved without a conversion");
    property p_addr_pre;
        cnt_q < 3'h3 |-> slave_addr == `TMC_ADDR_DEFAULT;
    endproperty
    a_addr_pre: assert property (p_addr_pre)
        else $error("slave address wrong before capture");
    property p_strap;
        cnt_q == 3'h6 |-> slave_addr == strap_addr;
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap address wrong");
    property p_strap_once;
        cnt_q == 3'h7 |-> $stable(slave_addr);
    endproperty
    a_strap_once: assert property (p_strap_once)
        else $error("slave address changed after capture");
    property p_lock;
        addr_latch && cnt_q == 3'h7 |=> addr_locked [*3];
    endproperty
    a_lock: assert property (p_lock)
        else $error("address not locked");

    c_wrap: cover property (adc_start && adc_chan == `TMC_CH_LAST);
    c_lock: cover property ($rose(addr_locked));
    c_err: cover property (pslverr);
endmodule

bind tmc_core tmc_core_properties tmc_core_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
    .addr_enable_pin(addr_enable_pin), .addr_select_pin(addr_select_pin),
    .addr_latch(addr_latch), .slave_addr(slave_addr),
    .addr_locked(addr_locked), .fan_drive(fan_drive)
);
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_defines.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, adc_data, fan_value;
    logic [31:0] pwdata, prdata, rd;
    logic        adc_start, adc_done, fan_valid, en_pin, sel_pin;
    logic [2:0]  adc_chan;
    logic [1:0]  fan_idx;
    logic        addr_latch, addr_locked, a5_o, a5_oe_n, a14_o, a14_oe_n;
    logic [6:0]  slave_addr;
    logic [23:0] fan_drive;
    logic [3:0]  dly;
    logic [39:0] vals;
    logic        er;
    int          error_cnt, n_tests;

    tmc_core tmc_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_start(adc_start),
        .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data),
        .fan_valid(fan_valid), .fan_idx(fan_idx), .fan_value(fan_value),
        .addr_enable_pin(en_pin), .addr_select_pin(sel_pin),
        .addr_latch(addr_latch), .slave_addr(slave_addr),
        .addr_locked(addr_locked), .alert5_o(a5_o), .alert5_oe_n(a5_oe_n),
        .alert14_o(a14_o), .alert14_oe_n(a14_oe_n), .fan_drive(fan_drive)
    );
    tmc_adc_model tmc_adc_model_inst (
        .pclk(pclk), .presetn(presetn), .adc_start(adc_start),
        .adc_chan(adc_chan), .delay(dly), .chan_vals(vals),
        .adc_done(adc_done), .adc_data(adc_data)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task hang(input string nm);
        error_cnt++;
        $display("BAD %s expected done seen timeout", nm);
        tally_and_finish();
    endtask
    // settle past the edge's updates before looking
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task apb(input logic wr, input logic [5:0] ix, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [5:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
    endtask
    task rdc(input logic [5:0] ix, input logic [31:0] exp, input string nm);
        apb(1'b0, ix, 8'h00);
        check(nm, rd, exp);
    endtask
    task wait_done(input int k);
        int n;
        n = 0;
        while (k > 0 && n < 400) begin
            @(posedge pclk);
            if (adc_done === 1'b1) k--;
            n++;
        end
        if (k > 0) hang("conversion");
    endtask

    task t_lock;
        check("strap", slave_addr, `TMC_ADDR_SEL1);
        @(posedge pclk);
        en_pin <= 1'b1;
        sel_pin <= 1'b0;
        addr_latch <= 1'b1;
        @(posedge pclk);
        addr_latch <= 1'b0;
        cyc(6);
        check("late_strap", slave_addr, `TMC_ADDR_SEL1);
        check("locked", addr_locked, 1'b1);
        wr(`TMC_IX_ADDR, 8'h00);
        rdc(`TMC_IX_ADDR, 32'had, "addr_reg");
    endtask
    task t_map;
        apb(1'b0, 6'h31, 8'h00);
        check("rd_err", er, 1'b1);
        check("rd_unmapped", rd, 32'h0);
        wr(6'h3f, 8'h00);
        check("wr_err", er, 1'b1);
        wr(`TMC_IX_PTR, {2'b00, `TMC_IX_OPNT});
        wr(`TMC_IX_DATA, 8'h55);
        rdc(`TMC_IX_OPNT, 32'h55, "opnt");
        rdc(`TMC_IX_DATA, 32'h55, "data");
        wr(`TMC_IX_PTR, 8'h35);
        apb(1'b0, `TMC_IX_DATA, 8'h00);
        check("ptr_err", er, 1'b1);
    endtask
    task t_monitor;
        logic [39:0] hi, lo, ev;
        hi = 40'h05_7f_7f_ff_40;
        lo = 40'h80_00_80_00_00;
        ev = 40'h10_90_2e_30_50;
        for (int i = 0; i < 5; i++) begin
            wr(6'(`TMC_IX_HIGH + i), hi[8*i +: 8]);
            wr(6'(`TMC_IX_LOW + i), lo[8*i +: 8]);
        end
        wr(`TMC_IX_OFS, 8'hfe);
        wr(6'(`TMC_IX_OFS + 1), 8'h00);
        wr(6'(`TMC_IX_OFS + 2), 8'h00);
        wr(`TMC_IX_FAN_START_TEMPERATURE, 8'h20);
        wr(`TMC_IX_TRNG, 8'h02);
        wr(`TMC_IX_ACOU, 8'h00);
        wr(`TMC_IX_CFG, 8'h03);
        wait_done(6);
        for (int i = 0; i < 5; i++)
            rdc(6'(`TMC_IX_VAL + i), {24'h0, ev[8*i +: 8]}, "val");
        rdc(`TMC_IX_STS1, 32'h19, "sts1");
        rdc(`TMC_IX_DRV, 32'h38, "drv_reg");
        check("drive", fan_drive, 24'h10_00_38);
        check("od_level", {a5_o, a14_o}, 2'b00);
        check("alert5", a5_oe_n, 1'b0);
        check("alert14", a14_oe_n, 1'b1);
    endtask
    task t_alert;
        wr(`TMC_IX_MSK1, 8'h19);
        cyc(3);
        check("masked", a5_oe_n, 1'b1);
        wr(`TMC_IX_MSK1, 8'h00);
        wr(`TMC_IX_CFG, 8'h05);
        cyc(3);
        check("alert5_off", a5_oe_n, 1'b1);
        check("alert14_on", a14_oe_n, 1'b0);
        wr(`TMC_IX_HIGH, 8'hff);
        wr(`TMC_IX_STS1, 8'h01);
        dly <= 4'h9;
        wait_done(6);
        rdc(`TMC_IX_STS1, 32'h18, "sts1_clr");
    endtask
    // two zone0 results in dynamic mode: start walks down, step of one
    task t_dyn;
        wr(`TMC_IX_OPNT, 8'h10);
        wr(`TMC_IX_ACOU, 8'h01);
        wr(`TMC_IX_CFG, 8'h09);
        wait_done(10);
        cyc(1);
        check("dyn_drive", fan_drive[7:0], 8'h39);
    endtask
    task t_fan;
        wr(6'(`TMC_IX_FLIM + 1), 8'h40);
        @(posedge pclk);
        fan_valid <= 1'b1;
        fan_idx <= 2'h1;
        fan_value <= 8'h30;
        @(posedge pclk);
        fan_valid <= 1'b0;
        rdc(6'(`TMC_IX_FVAL + 1), 32'h30, "fan_val");
        rdc(`TMC_IX_STS2, 32'h02, "sts2");
    endtask
    task t_strap;
        logic [5:0]  pins;
        logic [20:0] ea;
        pins = 6'b01_00_10;
        ea = {`TMC_ADDR_SEL1, `TMC_ADDR_SEL0, `TMC_ADDR_DEFAULT};
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            presetn <= 1'b0;
            {en_pin, sel_pin} <= pins[2*i +: 2];
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            cyc(8);
            check("strap", slave_addr, ea[7*i +: 7]);
            check("unlocked", addr_locked, 1'b0);
        end
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fan_valid = 1'b0;
        fan_idx = 2'h0;
        fan_value = 8'h00;
        en_pin = 1'b0;
        sel_pin = 1'b1;
        addr_latch = 1'b0;
        dly = 4'h1;
        vals = 40'h10_90_30_30_50;
        error_cnt = 0;
        n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(8);
        t_lock();
        t_map();
        t_monitor();
        t_alert();
        t_dyn();
        t_fan();
        t_strap();
        tally_and_finish();
    end
endmodule
`default_nettype wire
